/* File: adc_serial_readout.sv */
`include "adc_serial_readout_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module adc_serial_readout #(
  parameter int RATE_DIV       = `ADC_RATE_DIV,
  parameter int SETTLE_PERIODS = `ADC_SETTLE_PERIODS,
  parameter int LOCK_EDGES     = `ADC_PLL_LOCK_EDGES,
  parameter int SCLK_HALF      = `ADC_SCLK_HALF_CYCLES
) (
  input  wire logic                               core_clk_i,
  input  wire logic                               rst_n_i,
  input  wire logic                               sel_n_i,
  input  wire logic                               mode_i,
  input  wire logic                               crystal_in_i,
  input  wire logic                               input_pair_select_i,
  input  wire logic                               range_i,
  input  wire logic                               sclk_i,
  output logic                                    sclk_o,
  output logic                                    sclk_oe_o,
  output logic                                    dout_rdy_n_o,
  output logic                                    dout_oe_o,
  input  wire logic signed [`ADC_RESULT_BITS-1:0] conv_sample_i,
  output logic                                    input_pair_o,
  output logic [`ADC_GAIN_W-1:0]                  gain_amplifier_o,
  output logic                                    span_wide_o,
  output logic                                    pll_locked_o,
  output logic                                    mod_sample_o,
  output logic                                    converting_o
);

  adc_serial_readout_pkg::readout_regs_t s_q;
  adc_serial_readout_pkg::readout_regs_t s_d;

  logic [`ADC_SYNC_W-1:0] pins;
  logic                   cs_high;
  logic                   master;
  logic                   xtal_rise;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   half_done;
  logic                   result_now;
  logic                   running;

  // two's complement filter output to offset binary: adding 2^23 flips the top bit
  function automatic logic [`ADC_RESULT_BITS-1:0] to_offset_binary(
    input logic [`ADC_RESULT_BITS-1:0] sample
  );
    to_offset_binary = sample ^ `ADC_CODE_MIDSCALE;
  endfunction

  // every pin from the far side passes the three-stage synchroniser
  pin_sync3 #(
    .W        (`ADC_SYNC_W),
    .IDLE_VAL (`ADC_SYNC_IDLE)
  ) u_pin_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .pin_i      ({crystal_in_i, range_i, input_pair_select_i, sclk_i, mode_i, sel_n_i}),
    .level_o    (pins)
  );

  // edges are found on the synchronised levels only
  always_comb begin
    cs_high   = pins[`ADC_SYNC_CS];
    master    = ~pins[`ADC_SYNC_MODE];
    xtal_rise = pins[`ADC_SYNC_XTAL] & ~s_q.xtal_prev;
    sclk_rise = pins[`ADC_SYNC_SCLK] & ~s_q.sclk_prev;
    sclk_fall = ~pins[`ADC_SYNC_SCLK] & s_q.sclk_prev;
    half_done = (s_q.half_cnt == `ADC_HALF_W'(SCLK_HALF - 1));
    running   = (s_q.state != adc_serial_readout_pkg::ST_STANDBY) &&
                (s_q.state != adc_serial_readout_pkg::ST_LOCK);
  end

  always_comb begin
    s_d            = s_q;
    result_now     = 1'b0;
    s_d.xtal_prev  = pins[`ADC_SYNC_XTAL];
    s_d.sclk_prev  = pins[`ADC_SYNC_SCLK];
    s_d.mod_sample = running & xtal_rise & ~cs_high;
    s_d.gain       = pins[`ADC_SYNC_RANGE] ? `ADC_GAIN_WIDE : `ADC_GAIN_NARROW;
    s_d.half_cnt   = half_done ? '0 : s_q.half_cnt + `ADC_HALF_W'(1);

    // result timer runs in every converting state, so conversions never pause
    if (running) begin
      if (pins[`ADC_SYNC_PAIR] != s_q.pair) begin
        s_d.pair     = pins[`ADC_SYNC_PAIR];
        s_d.rate_cnt = '0;
        s_d.settle   = '0;
      end else if (xtal_rise) begin
        if (s_q.rate_cnt == `ADC_RATE_W'(RATE_DIV - 1)) begin
          s_d.rate_cnt = '0;
          if (s_q.settle == 2'(SETTLE_PERIODS - 1)) begin
            result_now = 1'b1;
          end else begin
            s_d.settle = s_q.settle + 2'd1;
          end
        end else begin
          s_d.rate_cnt = s_q.rate_cnt + `ADC_RATE_W'(1);
        end
      end
    end

    if (cs_high) begin
      // standby drops the word, the bit, rate, settle and lock counts and the lock, including an unread result
      s_d.state    = adc_serial_readout_pkg::ST_STANDBY;
      s_d.shreg    = '0;
      s_d.dout     = 1'b1;
      s_d.sclk     = 1'b1;
      s_d.bitcnt   = '0;
      s_d.rate_cnt = '0;
      s_d.settle   = '0;
      s_d.lock_cnt = '0;
      s_d.locked   = 1'b0;
    end else begin
      unique case (s_q.state)
        adc_serial_readout_pkg::ST_STANDBY: begin
          s_d.state    = adc_serial_readout_pkg::ST_LOCK;
          s_d.pair     = pins[`ADC_SYNC_PAIR];
          s_d.lock_cnt = '0;
        end
        adc_serial_readout_pkg::ST_LOCK: begin
          // lock is declared after a fixed count of crystal edges
          if (xtal_rise) begin
            s_d.lock_cnt = s_q.lock_cnt + `ADC_LOCK_W'(1);
            if (s_q.lock_cnt == `ADC_LOCK_W'(LOCK_EDGES - 1)) begin
              s_d.locked   = 1'b1;
              s_d.state    = adc_serial_readout_pkg::ST_CONVERT;
              s_d.rate_cnt = '0;
              s_d.settle   = '0;
            end
          end
        end
        adc_serial_readout_pkg::ST_CONVERT: begin
          s_d.dout = 1'b1;
          s_d.sclk = 1'b1;
          if (result_now) begin
            s_d.state = adc_serial_readout_pkg::ST_UPDATE;
          end
        end
        adc_serial_readout_pkg::ST_UPDATE: begin
          // line has been high for at least this cycle before the reload
          s_d.shreg    = to_offset_binary(conv_sample_i);
          s_d.bitcnt   = '0;
          s_d.half_cnt = '0;
          s_d.dout     = 1'b0;
          s_d.state    = adc_serial_readout_pkg::ST_READY;
        end
        adc_serial_readout_pkg::ST_READY: begin
          if (result_now) begin
            // unread word is replaced; raise the line first
            s_d.dout  = 1'b1;
            s_d.state = adc_serial_readout_pkg::ST_UPDATE;
          end else if (master ? half_done : sclk_fall) begin
            s_d.sclk   = ~master;
            s_d.dout   = s_q.shreg[`ADC_RESULT_BITS-1];
            s_d.shreg  = s_q.shreg << 1;
            s_d.state  = adc_serial_readout_pkg::ST_SHIFT;
          end
        end
        adc_serial_readout_pkg::ST_SHIFT: begin
          // results landing mid-word are dropped so the word stays intact
          if (master) begin
            if (half_done && !s_q.sclk) begin
              s_d.sclk   = 1'b1;
              s_d.bitcnt = s_q.bitcnt + `ADC_BITCNT_W'(1);
            end else if (half_done &&
                         s_q.bitcnt == `ADC_BITCNT_W'(`ADC_RESULT_BITS)) begin
              // release the line half a period after the last rising edge
              s_d.dout  = 1'b1;
              s_d.state = adc_serial_readout_pkg::ST_CONVERT;
            end else if (half_done) begin
              s_d.sclk  = 1'b0;
              s_d.dout  = s_q.shreg[`ADC_RESULT_BITS-1];
              s_d.shreg = s_q.shreg << 1;
            end
          end else begin
            // bit position survives gaps between bursts
            if (sclk_fall) begin
              s_d.dout  = s_q.shreg[`ADC_RESULT_BITS-1];
              s_d.shreg = s_q.shreg << 1;
            end else if (sclk_rise) begin
              s_d.bitcnt = s_q.bitcnt + `ADC_BITCNT_W'(1);
              if (s_q.bitcnt == `ADC_BITCNT_W'(`ADC_RESULT_BITS - 1)) begin
                s_d.dout  = 1'b1;
                s_d.state = adc_serial_readout_pkg::ST_CONVERT;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{state: adc_serial_readout_pkg::ST_STANDBY, sclk: 1'b1, dout: 1'b1,
               gain: `ADC_GAIN_NARROW, xtal_prev: 1'b1, sclk_prev: 1'b1, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // pins are released in standby; the clock is driven only in master mode
  assign sclk_o           = s_q.sclk;
  assign sclk_oe_o        = ~cs_high & master & running;
  assign dout_rdy_n_o     = s_q.dout;
  assign dout_oe_o        = ~cs_high;
  assign input_pair_o     = s_q.pair;
  assign gain_amplifier_o = s_q.gain;
  assign span_wide_o      = (s_q.gain == `ADC_GAIN_WIDE);
  assign pll_locked_o     = s_q.locked;
  assign mod_sample_o     = s_q.mod_sample;
  assign converting_o     = running;

endmodule

`default_nettype wire

/* File: adc_serial_readout_defs.svh */
`ifndef ADC_SERIAL_READOUT_DEFS_SVH
`define ADC_SERIAL_READOUT_DEFS_SVH

// result word
`define ADC_RESULT_BITS      24
`define ADC_BITCNT_W         5
`define ADC_CODE_MIDSCALE    24'h800000

// crystal, converter clock and result rate (rate counted in crystal edges)
`define ADC_XTAL_HZ          32768
`define ADC_PLL_MULT         128
`define ADC_CONV_CLK_HZ      (`ADC_XTAL_HZ * `ADC_PLL_MULT)
`define ADC_RATE_DIV         (69 * 8 * 3)
`define ADC_RATE_W           11
`define ADC_SETTLE_PERIODS   2
`define ADC_PLL_LOCK_EDGES   32
`define ADC_LOCK_W           8

// core clock and master-mode serial clock half period
`define ADC_CORE_CLK_NS      8
`define ADC_SCLK_HALF_NS     256
`define ADC_SCLK_HALF_CYCLES ((`ADC_SCLK_HALF_NS + `ADC_CORE_CLK_NS - 1) / `ADC_CORE_CLK_NS)
`define ADC_HALF_W           8

// gain per span
`define ADC_GAIN_NARROW      5'h10
`define ADC_GAIN_WIDE        5'h01
`define ADC_GAIN_W           5

// synchronised pin vector layout and its idle value
`define ADC_SYNC_W           6
`define ADC_SYNC_CS          0
`define ADC_SYNC_MODE        1
`define ADC_SYNC_SCLK        2
`define ADC_SYNC_PAIR        3
`define ADC_SYNC_RANGE       4
`define ADC_SYNC_XTAL        5
`define ADC_SYNC_IDLE        6'h07

`endif

/* File: adc_serial_readout_pkg.sv */
`include "adc_serial_readout_defs.svh"

package adc_serial_readout_pkg;

  typedef enum logic [5:0] {
    ST_STANDBY = 6'h01,
    ST_LOCK    = 6'h02,
    ST_CONVERT = 6'h04,
    ST_UPDATE  = 6'h08,
    ST_READY   = 6'h10,
    ST_SHIFT   = 6'h20
  } readout_state_t;

  typedef struct packed {
    readout_state_t                state;
    logic                          sclk;
    logic                          dout;
    logic [`ADC_RESULT_BITS-1:0]   shreg;
    logic [`ADC_BITCNT_W-1:0]      bitcnt;
    logic [`ADC_RATE_W-1:0]        rate_cnt;
    logic [1:0]                    settle;
    logic [`ADC_LOCK_W-1:0]        lock_cnt;
    logic [`ADC_HALF_W-1:0]        half_cnt;
    logic                          pair;
    logic [`ADC_GAIN_W-1:0]        gain;
    logic                          locked;
    logic                          mod_sample;
    logic                          xtal_prev;
    logic                          sclk_prev;
  } readout_regs_t;

endpackage

/* File: pin_sync3.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter int           W        = 1,
  parameter logic [W-1:0] IDLE_VAL = '0
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] level_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] level;
  } sync_regs_t;

  sync_regs_t   s_q;
  sync_regs_t   s_d;
  logic [W-1:0] agree;

  // stage one feeds stage two only; a change is taken once two and three agree
  always_comb begin
    s_d    = s_q;
    s_d.s1 = pin_i;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.level[i] = s_q.s3[i];
      end
    end
  end

  // pins reset to their idle level so no false edge is seen on release
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '{s1: IDLE_VAL, s2: IDLE_VAL, s3: IDLE_VAL, level: IDLE_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  // the agreed value is passed on at once: a pin change costs three edges, not four,
  // which keeps slave-mode data ahead of a 32 ns low phase of the reader's clock
  assign agree   = ~(s_q.s2 ^ s_q.s3);
  assign level_o = (agree & s_q.s3) | (~agree & s_q.level);

endmodule

`default_nettype wire

/* File: adc_serial_readout_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_readout_defs.svh"
module adc_readout_checker #(
  parameter int SCLK_HALF = 32
) (
  input wire logic                   core_clk_i,
  input wire logic                   rst_n_i,
  input wire logic                   sel_n_i,
  input wire logic                   range_i,
  input wire logic                   input_pair_select_i,
  input wire logic                   sclk_o,
  input wire logic                   sclk_oe_o,
  input wire logic                   dout_rdy_n_o,
  input wire logic                   dout_oe_o,
  input wire logic                   input_pair_o,
  input wire logic [`ADC_GAIN_W-1:0] gain_amplifier_o,
  input wire logic                   span_wide_o,
  input wire logic                   pll_locked_o,
  input wire logic                   mod_sample_o,
  input wire logic                   converting_o
);
  logic [5:0] falls_q;
  logic [7:0] low_q;
  // clock falls since the last ready mark, and cycles spent in the current low phase
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      falls_q <= 6'h00;
      low_q   <= 8'h00;
    end else begin
      low_q <= sclk_o ? 8'h00 : low_q + 8'h01;
      if (sel_n_i || !sclk_oe_o || ($fell(dout_rdy_n_o) && sclk_o)) begin
        falls_q <= 6'h00;
      end else if ($fell(sclk_o)) begin
        falls_q <= falls_q + 6'h01;
      end
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  // pins cross a three-flop synchroniser, so steady windows are kept generous
  sequence s_standby; sel_n_i [*7]; endsequence
  sequence s_range_ok; $stable(range_i) [*8] ##0 converting_o; endsequence
  sequence s_pair_ok; $stable(input_pair_select_i) [*8] ##0 converting_o; endsequence
  property p_off; s_standby |-> !dout_oe_o && !sclk_oe_o && !pll_locked_o; endproperty
  a_off: assert property (p_off) else $error("outputs live in standby");
  property p_gain; s_range_ok |-> span_wide_o == range_i &&
    gain_amplifier_o == (range_i ? `ADC_GAIN_WIDE : `ADC_GAIN_NARROW); endproperty
  a_gain: assert property (p_gain) else $error("gain does not follow range pin");
  property p_pair; s_pair_ok |-> input_pair_o == input_pair_select_i; endproperty
  a_pair: assert property (p_pair) else $error("wrong input pair");
  property p_mod; mod_sample_o |-> converting_o ##1 !mod_sample_o; endproperty
  a_mod: assert property (p_mod) else $error("bad modulator strobe");
  property p_data; sclk_oe_o && !sclk_o && !$fell(sclk_o) |-> $stable(dout_rdy_n_o); endproperty
  a_data: assert property (p_data) else $error("data moved inside low phase");
  property p_half; sclk_oe_o && $rose(sclk_o) |-> low_q == SCLK_HALF; endproperty
  a_half: assert property (p_half) else $error("low phase length wrong");
  property p_count; falls_q == 6'h18 |-> !$fell(sclk_o); endproperty
  a_count: assert property (p_count) else $error("more than a word of clocks");
  property p_ready; sclk_oe_o && sclk_o && $fell(dout_rdy_n_o) |->
    falls_q == 6'h00 || falls_q == 6'h18; endproperty
  a_ready: assert property (p_ready) else $error("ready mark inside a word");
endmodule
bind adc_serial_readout adc_readout_checker #(.SCLK_HALF(SCLK_HALF)) u_checker (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sel_n_i(sel_n_i), .range_i(range_i),
  .input_pair_select_i(input_pair_select_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o),
  .dout_rdy_n_o(dout_rdy_n_o), .dout_oe_o(dout_oe_o), .input_pair_o(input_pair_o),
  .gain_amplifier_o(gain_amplifier_o), .span_wide_o(span_wide_o),
  .pll_locked_o(pll_locked_o), .mod_sample_o(mod_sample_o), .converting_o(converting_o));
`default_nettype wire

/* File: host_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none
module host_reader_model (
  input  wire logic        core_clk_i,
  input  wire logic        mode_i,
  input  wire logic        rd_en_i,
  input  wire logic        burst_i,
  input  wire logic        sclk_w_i,
  input  wire logic        dout_w_i,
  output logic             sclk_o,
  output logic      [23:0] word_o,
  output logic      [7:0]  n_words_o
);
  logic [23:0] shift;
  // reader: waits for the ready mark, then clocks in or follows 24 bits
  initial begin
    sclk_o = 1'b1;
    word_o = 24'h000000;
    n_words_o = 8'h00;
    forever begin
      @(negedge core_clk_i);
      if (rd_en_i && !dout_w_i) begin
        for (int i = 0; i < 24; i++) begin
          if (mode_i) begin
            #1 sclk_o = 1'b0;
            #32 sclk_o = 1'b1;
            shift = {shift[22:0], dout_w_i};
            #31;
            if (burst_i && i % 8 == 7) #200;
          end else begin
            @(posedge sclk_w_i);
            shift = {shift[22:0], dout_w_i};
          end
        end
        word_o = shift;
        n_words_o = n_words_o + 8'h01;
        wait (dout_w_i);
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "adc_serial_readout_defs.svh"
module tb;
  logic core_clk = 1'b0, rst_n = 1'b0, sel_n = 1'b1, mode = 1'b0, xtal = 1'b0;
  logic pair = 1'b0, range = 1'b0, rd_en = 1'b1, burst = 1'b0;
  logic sclk_dev, sclk_oe, dout, dout_oe, host_sclk, in_pair, span, locked, strobe, conv;
  logic [4:0]  gain;
  logic [7:0]  n_words;
  logic [23:0] word, sample = 24'h800000;
  logic [23:0] corner [3] = '{24'h000000, 24'h7FFFFF, 24'h5A5A5A};
  int          n_errors = 0, cmp_count = 0, cyc = 0, pick = 0, lat = 0;
  // both shared lines carry pull-ups, so a released line reads high
  wire logic   sclk_w = sclk_oe ? sclk_dev : (mode ? host_sclk : 1'b1);
  wire logic   dout_w = dout_oe ? dout : 1'b1;
  adc_serial_readout #(.RATE_DIV(8), .SETTLE_PERIODS(2), .LOCK_EDGES(2), .SCLK_HALF(4)) DUT (
    .core_clk_i(core_clk), .rst_n_i(rst_n), .sel_n_i(sel_n), .mode_i(mode),
    .crystal_in_i(xtal), .input_pair_select_i(pair), .range_i(range), .sclk_i(sclk_w),
    .sclk_o(sclk_dev), .sclk_oe_o(sclk_oe), .dout_rdy_n_o(dout), .dout_oe_o(dout_oe),
    .conv_sample_i(sample), .input_pair_o(in_pair), .gain_amplifier_o(gain),
    .span_wide_o(span), .pll_locked_o(locked), .mod_sample_o(strobe), .converting_o(conv));
  host_reader_model host (.core_clk_i(core_clk), .mode_i(mode), .rd_en_i(rd_en),
    .burst_i(burst), .sclk_w_i(sclk_w), .dout_w_i(dout_w), .sclk_o(host_sclk),
    .word_o(word), .n_words_o(n_words));
  // crystal sped up to 50 core cycles a period to keep the run short
  always #4 core_clk = ~core_clk;
  always #200 xtal = ~xtal;
  // hang guard: the whole run needs about 7700 cycles
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end
  function logic [23:0] exp_code(input logic [23:0] s);
    return {~s[23], s[22:0]};
  endfunction
  function logic [4:0] exp_gain(input logic r);
    return r ? `ADC_GAIN_WIDE : `ADC_GAIN_NARROW;
  endfunction
  task chk_vec(input string what, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_bit(input string what, input logic exp, input logic got);
    chk_vec(what, {23'h0, exp}, {23'h0, got});
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // bounded wait for the ready mark; lat holds the cycles spent
  task wait_ready();
    lat = 0;
    while (dout !== 1'b0 && lat < 2000) begin
      @(negedge core_clk);
      lat++;
    end
    chk_bit("ready mark", 1'b0, dout);
  endtask
  // one word through the reader, then a fresh sample well before the next result
  task get_word();
    logic [7:0] n0;
    int k;
    n0 = n_words;
    k = 0;
    while (n_words === n0 && k < 3000) begin
      @(negedge core_clk);
      k++;
    end
    chk_bit("word arrived", 1'b1, n_words !== n0);
    chk_vec("word", exp_code(sample), word);
    sample = (pick < 3) ? corner[pick] : 24'($urandom);
    pick++;
  endtask
  task session(input logic m, input int nw, input logic b);
    sel_n = 1'b1;
    mode = m;
    burst = b;
    // narrow span in the master run and wide in the slave run, so both gains are seen
    range = m;
    pair = 1'($urandom);
    repeat (12) @(negedge core_clk);
    sel_n = 1'b0;
    repeat (nw) get_word();
    chk_vec("gain", {19'h0, exp_gain(range)}, {19'h0, gain});
    chk_bit("pair", pair, in_pair);
    chk_bit("clock idle", 1'b1, sclk_w);
  endtask
  initial begin
    void'($urandom(32'hA35B));
    repeat (20) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    chk_bit("ready idle", 1'b1, dout);
    session(1'b0, 5, 1'b0);
    $display("test master done");
    session(1'b1, 5, 1'b1);
    $display("test slave bursts done");
    pair = ~pair;
    wait_ready();
    chk_bit("settle wait", 1'b1, lat >= 740 && lat <= 830);
    get_word();
    chk_bit("pair", pair, in_pair);
    $display("test pair switch done");
    // abort while an unread result is pending
    rd_en = 1'b0;
    wait_ready();
    sel_n = 1'b1;
    repeat (8) @(negedge core_clk);
    chk_bit("data oe", 1'b0, dout_oe);
    chk_bit("locked", 1'b0, locked);
    // a fresh sample makes a replayed stale word show up as a mismatch
    sample = 24'($urandom);
    sel_n = 1'b0;
    wait_ready();
    chk_bit("restart wait", 1'b1, lat >= 840 && lat <= 930);
    chk_bit("locked", 1'b1, locked);
    rd_en = 1'b1;
    get_word();
    $display("test abort done");
    close_out();
  end
endmodule
`default_nettype wire
